// ### src/flash_limit_consts.svh
`ifndef FLASH_LIMIT_CONSTS_SVH
`define FLASH_LIMIT_CONSTS_SVH

`define FTC_SFR_ADDR 8'hb6
`define FTC_RESET 8'h8f
`define FTC_WRITE_MASK 8'hcf
`define FTC_ONESHOT_BIT 7
`define FTC_CONT_READ_BIT 6
`define FTC_CODE_MSB 3
`define FTC_CODE_LSB 0
`define PRESCALE_DISABLED 4'hf
`define PRESCALE_MAX_RATE 4'ha
`define BLOCKED_READ_DATA 8'h00
`define BOUNDARY_LOW_BYTE 8'h00
`define RESET_VECTOR 16'h0000
`define DIV_COUNT_ONE 11'h001
`define DIV_COUNT_ZERO 11'h000

`endif

// ### src/flash_limit_pkg.sv
`include "flash_limit_consts.svh"

package flash_limit_pkg;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [15:0] code_addr_t;
    typedef logic [3:0] prescale_code_t;
    typedef logic [10:0] div_count_t;

    // Boundary is limit byte over a zero low byte
    function automatic code_addr_t boundary_of(input sfr_byte_t lim);
        return {lim, `BOUNDARY_LOW_BYTE};
    endfunction

    // Upper partition is everything at or above the boundary
    function automatic logic in_upper(input code_addr_t a,
                                      input sfr_byte_t lim);
        return a >= boundary_of(lim);
    endfunction
endpackage

// ### src/read_limit_check.sv
`timescale 1ns/100ps

module read_limit_check (
    input wire flash_limit_pkg::sfr_byte_t limit_byte,
    input wire flash_limit_pkg::code_addr_t exec_pc,
    input wire flash_limit_pkg::code_addr_t read_addr,
    output flash_limit_pkg::code_addr_t boundary,
    output logic exec_upper,
    output logic read_blocked
);
    import flash_limit_pkg::*;

    always_comb begin
        boundary = boundary_of(limit_byte);
        exec_upper = in_upper(exec_pc, limit_byte);
        // Only upper code reading lower content is refused
        read_blocked = exec_upper
            && !in_upper(read_addr, limit_byte);
    end
endmodule // read_limit_check

// ### src/flash_read_limit_and_timing.sv
`timescale 1ns/100ps
`include "flash_limit_consts.svh"

module flash_read_limit_and_timing (
    input wire logic clock,
    input wire logic sys_rst,
    input wire flash_limit_pkg::sfr_byte_t sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire flash_limit_pkg::sfr_byte_t sfr_wdata,
    output flash_limit_pkg::sfr_byte_t sfr_rdata,
    input wire flash_limit_pkg::sfr_byte_t limit_byte,
    input wire flash_limit_pkg::code_addr_t exec_pc,
    input wire logic code_read_op,
    input wire flash_limit_pkg::code_addr_t code_read_addr,
    input wire flash_limit_pkg::sfr_byte_t flash_read_data,
    output logic code_read_valid,
    output flash_limit_pkg::sfr_byte_t code_read_data,
    input wire logic fetch_req,
    input wire flash_limit_pkg::sfr_byte_t flash_fetch_data,
    output logic fetch_valid,
    output flash_limit_pkg::sfr_byte_t fetch_data,
    output flash_limit_pkg::code_addr_t reset_vector,
    output logic boot_fetch,
    output logic oneshot_read_timer_enable,
    output logic continuous_read_enable,
    output flash_limit_pkg::prescale_code_t write_erase_prescale_code,
    output logic prescale_reserved,
    input wire logic write_erase_req,
    output logic write_erase_grant,
    output logic write_erase_tick
);
    import flash_limit_pkg::*;

    sfr_byte_t ctrl_reg, ctrl_next;
    sfr_byte_t rdata_reg, rdata_next;
    logic rd_valid_reg, rd_valid_next;
    sfr_byte_t rd_data_reg, rd_data_next;
    logic f_valid_reg, f_valid_next;
    sfr_byte_t f_data_reg, f_data_next;
    logic boot_reg, boot_next;
    logic grant_reg, grant_next;
    logic tick_reg, tick_next;
    div_count_t div_reg, div_next;
    div_count_t div_period;
    code_addr_t boundary;
    logic exec_upper;
    logic read_blocked;
    logic we_allowed;

    read_limit_check limit_chk (
        .limit_byte(limit_byte),
        .exec_pc(exec_pc),
        .read_addr(code_read_addr),
        .boundary(boundary),
        .exec_upper(exec_upper),
        .read_blocked(read_blocked)
    );

    // Register access and its view
    always_comb begin
        ctrl_next = ctrl_reg;
        if (sfr_wr && sfr_addr == `FTC_SFR_ADDR) begin
            ctrl_next = sfr_wdata & `FTC_WRITE_MASK;
        end
        rdata_next = '0;
        if (sfr_rd && sfr_addr == `FTC_SFR_ADDR) begin
            rdata_next = ctrl_reg & `FTC_WRITE_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_reg <= `FTC_RESET;
            rdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // Code-space reads and instruction fetches
    always_comb begin
        rd_valid_next = code_read_op;
        rd_data_next = rd_data_reg;
        if (code_read_op) begin
            if (read_blocked) begin
                rd_data_next = `BLOCKED_READ_DATA;
            end else begin
                rd_data_next = flash_read_data;
            end
        end
        // Fetches never pass the limit check
        f_valid_next = fetch_req;
        f_data_next = fetch_req ? flash_fetch_data : f_data_reg;
        boot_next = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
            f_valid_reg <= 1'b0;
            f_data_reg <= '0;
            boot_reg <= 1'b1;
        end else begin
            rd_valid_reg <= rd_valid_next;
            rd_data_reg <= rd_data_next;
            f_valid_reg <= f_valid_next;
            f_data_reg <= f_data_next;
            boot_reg <= boot_next;
        end
    end

    // Write/erase timing from the prescale code
    always_comb begin
        we_allowed = ctrl_reg[`FTC_CODE_MSB:`FTC_CODE_LSB]
            != `PRESCALE_DISABLED;
        div_period = `DIV_COUNT_ONE
            << ctrl_reg[`FTC_CODE_MSB:`FTC_CODE_LSB];
        grant_next = write_erase_req && we_allowed;
        div_next = `DIV_COUNT_ZERO;
        tick_next = 1'b0;
        if (we_allowed && !prescale_reserved) begin
            if (div_reg >= div_period - `DIV_COUNT_ONE) begin
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + `DIV_COUNT_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            grant_reg <= 1'b0;
            tick_reg <= 1'b0;
            div_reg <= '0;
        end else begin
            grant_reg <= grant_next;
            tick_reg <= tick_next;
            div_reg <= div_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign code_read_valid = rd_valid_reg;
    assign code_read_data = rd_data_reg;
    assign fetch_valid = f_valid_reg;
    assign fetch_data = f_data_reg;
    assign reset_vector = `RESET_VECTOR;
    assign boot_fetch = boot_reg;
    assign oneshot_read_timer_enable = ctrl_reg[`FTC_ONESHOT_BIT];
    assign continuous_read_enable = ctrl_reg[`FTC_CONT_READ_BIT];
    assign write_erase_prescale_code =
        ctrl_reg[`FTC_CODE_MSB:`FTC_CODE_LSB];
    assign prescale_reserved = write_erase_prescale_code > `PRESCALE_MAX_RATE
        && write_erase_prescale_code != `PRESCALE_DISABLED;
    assign write_erase_grant = grant_reg;
    assign write_erase_tick = tick_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    blocked_read_zero_a: assert property (
        code_read_op && exec_upper && code_read_addr < boundary
        |=> code_read_valid && code_read_data == 8'h00)
        else $error("Lower content leaked to upper code");

    lower_read_open_a: assert property (
        code_read_op && !exec_upper
        |=> code_read_data == $past(flash_read_data))
        else $error("Lower code read was altered");

    fetch_open_a: assert property (
        fetch_req |=> fetch_valid && fetch_data == $past(flash_fetch_data))
        else $error("Fetch was gated by read limit");

    boot_vector_a: assert property (
        $past(sys_rst) |-> boot_fetch && reset_vector == 16'h0000)
        else $error("No boot fetch at reset vector");

    boundary_form_a: assert property (
        boundary[7:0] == 8'h00 && boundary[15:8] == limit_byte)
        else $error("Boundary not formed from limit byte");

    unprogrammed_open_a: assert property (
        limit_byte == 8'h00 && code_read_op |=> code_read_data
        == $past(flash_read_data))
        else $error("Read blocked with zero limit");

    unused_bits_a: assert property (
        sfr_rd && sfr_addr == 8'hb6 |=> sfr_rdata[5:4] == 2'b00
        && sfr_rdata[7:6] == $past(ctrl_reg[7:6]))
        else $error("Unused bits not zero on read");

    mode_bits_a: assert property (
        sfr_wr && sfr_addr == 8'hb6 |=> oneshot_read_timer_enable
        == $past(sfr_wdata[7]) && continuous_read_enable
        == $past(sfr_wdata[6]))
        else $error("Mode bits do not follow write");

    we_blocked_a: assert property (
        write_erase_prescale_code == 4'hf |=> !write_erase_grant
        && !write_erase_tick)
        else $error("Write or erase not blocked");

    tick_spacing_a: assert property (
        write_erase_tick && write_erase_prescale_code == 4'h2
        ##1 (write_erase_prescale_code == 4'h2) [*3]
        |=> write_erase_tick && !$past(write_erase_tick)
        && !$past(write_erase_tick, 2) && !$past(write_erase_tick, 3))
        else $error("Tick period wrong for code two");
endmodule // flash_read_limit_and_timing

// ### sim/tb_flash_read_limit_and_timing.sv
`timescale 1ns/100ps

module tb_flash_read_limit_and_timing;
    import flash_limit_pkg::*;

    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    sfr_byte_t sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    sfr_byte_t sfr_wdata = 8'h00;
    sfr_byte_t sfr_rdata;
    sfr_byte_t limit_byte = 8'h00;
    code_addr_t exec_pc = 16'h0000;
    logic code_read_op = 1'b0;
    code_addr_t code_read_addr = 16'h0000;
    sfr_byte_t flash_read_data = 8'h00;
    logic code_read_valid;
    sfr_byte_t code_read_data;
    logic fetch_req = 1'b0;
    sfr_byte_t flash_fetch_data = 8'h00;
    logic fetch_valid;
    sfr_byte_t fetch_data;
    code_addr_t reset_vector;
    logic boot_fetch;
    logic oneshot_read_timer_enable;
    logic continuous_read_enable;
    prescale_code_t write_erase_prescale_code;
    logic prescale_reserved;
    logic write_erase_req = 1'b0;
    logic write_erase_grant;
    logic write_erase_tick;
    int failures = 0;
    int samples_checked = 0;
    int n;

    flash_read_limit_and_timing dut_u (.*);

    always #12.5 clock = ~clock;

    task automatic cyc();
        @(posedge clock);
        #1;
    endtask

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("failures %0d samples_checked %0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One register access, read data checked the cycle after the strobe
    task automatic sfr_op(input logic wr, input sfr_byte_t a,
                          input sfr_byte_t d, input sfr_byte_t exp);
        sfr_addr = a;
        sfr_wr = wr;
        sfr_rd = !wr;
        sfr_wdata = d;
        cyc();
        if (!wr) check("sfr_rdata", {8'h00, exp}, {8'h00, sfr_rdata});
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        cyc();
    endtask

    task automatic code_read(input code_addr_t pc, input code_addr_t a,
                             input sfr_byte_t fd, input sfr_byte_t exp);
        exec_pc = pc;
        code_read_addr = a;
        flash_read_data = fd;
        code_read_op = 1'b1;
        cyc();
        check("code_read_valid", 16'h0001, {15'h0, code_read_valid});
        check("code_read_data", {8'h00, exp}, {8'h00, code_read_data});
        code_read_op = 1'b0;
        cyc();
        check("code_read_valid low", 16'h0000, {15'h0, code_read_valid});
    endtask

    task automatic count_ticks(input int cycles, output int c);
        c = 0;
        repeat (cycles) begin
            cyc();
            if (write_erase_tick === 1'b1) c++;
        end
    endtask

    task automatic grant_try(input logic exp);
        write_erase_req = 1'b1;
        cyc();
        check("write_erase_grant", {15'h0, exp}, {15'h0, write_erase_grant});
        write_erase_req = 1'b0;
        cyc();
    endtask

    initial begin
        #(25 * 4000);
        failures++;
        finish_test();
    end

    initial begin
        repeat (10) cyc();
        check("boot_fetch in reset", 16'h0001, {15'h0, boot_fetch});
        check("reset_vector", 16'h0000, reset_vector);
        sys_rst = 1'b0;
        repeat (3) cyc();
        check("boot_fetch after", 16'h0000, {15'h0, boot_fetch});
        sfr_op(1'b0, 8'hb6, 8'h00, 8'h8f);
        check("oneshot reset", 16'h0001,
              {15'h0, oneshot_read_timer_enable});
        check("cont reset", 16'h0000,
              {15'h0, continuous_read_enable});
        grant_try(1'b0);
        sfr_op(1'b1, 8'hb6, 8'hff, 8'h00);
        sfr_op(1'b0, 8'hb6, 8'h00, 8'hcf);
        check("cont set", 16'h0001, {15'h0, continuous_read_enable});
        sfr_op(1'b1, 8'hb6, 8'h30, 8'h00);
        sfr_op(1'b0, 8'hb6, 8'h00, 8'h00);
        check("oneshot clr", 16'h0000,
              {15'h0, oneshot_read_timer_enable});
        sfr_op(1'b0, 8'hb7, 8'h00, 8'h00);
        // Boundary at 0x0200
        limit_byte = 8'h02;
        code_read(16'h0300, 16'h01ff, 8'ha5, 8'h00);
        code_read(16'h0200, 16'h0200, 8'h5a, 8'h5a);
        code_read(16'h01ff, 16'h0000, 8'h3c, 8'h3c);
        code_read(16'h0000, 16'h3dff, 8'hc3, 8'hc3);
        code_read(16'h0200, 16'h0000, 8'h96, 8'h00);
        limit_byte = 8'h01;
        code_read(16'h0100, 16'h00ff, 8'h69, 8'h00);
        limit_byte = 8'h00;
        code_read(16'h3000, 16'h0000, 8'h11, 8'h11);
        limit_byte = 8'h02;
        exec_pc = 16'h0300;
        flash_fetch_data = 8'h77;
        fetch_req = 1'b1;
        cyc();
        check("fetch_valid", 16'h0001, {15'h0, fetch_valid});
        check("fetch_data", 16'h0077, {8'h00, fetch_data});
        fetch_req = 1'b0;
        cyc();
        for (int c = 0; c < 4; c++) begin
            sfr_op(1'b1, 8'hb6, {4'h0, c[3:0]}, 8'h00);
            check("code", {12'h0, c[3:0]},
                  {12'h0, write_erase_prescale_code});
            grant_try(1'b1);
            count_ticks(32, n);
            check("ticks", 16'(32 >> c), 16'(n));
        end
        // Smallest code above log2 of 40 MHz over 50kHz
        sfr_op(1'b1, 8'hb6, 8'h0a, 8'h00);
        check("max rate code", 16'h000a,
              {12'h0, write_erase_prescale_code});
        check("max rate reserved", 16'h0000,
              {15'h0, prescale_reserved});
        grant_try(1'b1);
        sfr_op(1'b1, 8'hb6, 8'h0c, 8'h00);
        check("reserved", 16'h0001, {15'h0, prescale_reserved});
        count_ticks(32, n);
        check("reserved ticks", 16'h0000, 16'(n));
        sfr_op(1'b1, 8'hb6, 8'h0f, 8'h00);
        grant_try(1'b0);
        count_ticks(32, n);
        check("disabled ticks", 16'h0000, 16'(n));
        finish_test();
    end
endmodule // tb_flash_read_limit_and_timing
